// ==== cchi_defines.svh ====
// Register offsets, field positions and reset values of the codec host interface.
`ifndef CCHI_DEFINES_SVH
`define CCHI_DEFINES_SVH
`define CCHI_OFS_CTRL 8'h00
`define CCHI_OFS_STATUS 8'h04
`define CCHI_OFS_REPLY 8'h08
`define CCHI_OFS_CHAN 8'h20
`define CCHI_OFS_TXS 8'h40
`define CCHI_OFS_RXS 8'h60
`define CCHI_OFS_GCI 8'h80
`define CCHI_CTRL_FMT 0
`define CCHI_CTRL_HALF 1
`define CCHI_CTRL_EDGE 2
`define CCHI_CTRL_OFS 6:4
`define CCHI_STAT_BYTE_VLD 1
`define CCHI_CTRL_RST 7'h00
`define CCHI_CHAN_RST 16'h0000
`define CCHI_GCI_UP_RST 16'hFFFF
`define CCHI_READ_CMD_BIT 7
`define CCHI_SYNC_RST 13'h0400
`endif

// ==== cchi_pkg.sv ====
// Types shared by the codec host interface.
package cchi_pkg;
  typedef enum logic [1:0] {CCHI_IDLE, CCHI_CMD, CCHI_REPLY} cchi_ctl_state_type;
endpackage

// ==== cchi_top.sv ====
// Host interfaces of the eight-channel codec: control port, TDM highways and GCI link.
`timescale 1ns/10ps
`include "cchi_defines.svh"
module cchi_top #(
  parameter int NUM_CH = 8
) (
  // Clock and reset.
  input wire logic I_MCLK,
  input wire logic I_NRST,
  // AHB-Lite register slave.
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  // Mode pins.
  input wire logic I_INTERFACE_SELECT_N,
  input wire logic I_SLOT_HALF_SEL,
  input wire logic I_DOUBLE_RATE,
  // Serial control port.
  input wire logic I_SERIAL_CTRL_CLOCK,
  input wire logic I_CS_N,
  input wire logic I_CTRL_SERIAL_IN,
  output logic O_CTRL_SERIAL_OUT,
  output logic O_CTRL_SERIAL_OUT_EN,
  // TDM highways.
  input wire logic I_BIT_CLOCK,
  input wire logic I_HIGHWAY_FRAME_SYNC,
  input wire logic I_RX_HIGHWAY_IN_A,
  input wire logic I_RX_HIGHWAY_IN_B,
  output logic O_TX_HIGHWAY_OUT_A,
  output logic O_TX_HIGHWAY_OUT_A_EN,
  output logic O_TX_HIGHWAY_OUT_B,
  output logic O_TX_HIGHWAY_OUT_B_EN,
  // GCI link.
  input wire logic I_DATA_CLOCK,
  input wire logic I_GCI_FRAME_SYNC,
  input wire logic I_DOWNSTREAM_IN,
  output logic O_UPSTREAM_OUT,
  output logic O_UPSTREAM_OUT_EN
);
  import cchi_pkg::*;

  localparam int NUM_PAIR = NUM_CH / 2;

  if (NUM_CH != 8) begin : g_bad_ch
    $error("cchi_top serves exactly eight channels");
  end

  // ****************************************
  // Input synchronisers and edge detection
  // ****************************************
  logic [12:0] pins, meta_r, sync_r, last_r;
  assign pins = {I_INTERFACE_SELECT_N, I_SERIAL_CTRL_CLOCK, I_CS_N, I_CTRL_SERIAL_IN,
                 I_BIT_CLOCK, I_HIGHWAY_FRAME_SYNC, I_RX_HIGHWAY_IN_A, I_RX_HIGHWAY_IN_B,
                 I_DATA_CLOCK, I_GCI_FRAME_SYNC, I_DOWNSTREAM_IN, I_DOUBLE_RATE,
                 I_SLOT_HALF_SEL};

  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      meta_r <= `CCHI_SYNC_RST;
      sync_r <= `CCHI_SYNC_RST;
      last_r <= `CCHI_SYNC_RST;
    end else begin
      meta_r <= pins;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  logic gci_mode, cs_s, ci_s, fs_s, dra_s, drb_s, fsc_s, dd_s, dbl_s, tsel_s;
  logic serial_ctrl_clock_rise, serial_ctrl_clock_fall, bclk_rise, bclk_fall, dcl_rise, dcl_fall;
  assign gci_mode = sync_r[12];
  assign cs_s = sync_r[10];
  assign ci_s = sync_r[9];
  assign fs_s = sync_r[7];
  assign dra_s = sync_r[6];
  assign drb_s = sync_r[5];
  assign fsc_s = sync_r[3];
  assign dd_s = sync_r[2];
  assign dbl_s = sync_r[1];
  assign tsel_s = sync_r[0];
  assign serial_ctrl_clock_rise = sync_r[11] && !last_r[11];
  assign serial_ctrl_clock_fall = !sync_r[11] && last_r[11];
  assign bclk_rise = sync_r[8] && !last_r[8];
  assign bclk_fall = !sync_r[8] && last_r[8];
  assign dcl_rise = sync_r[4] && !last_r[4];
  assign dcl_fall = !sync_r[4] && last_r[4];

  // ****************************************
  // Register storage
  // ****************************************
  logic [6:0] ctrl_r;
  logic [7:0] reply_r, byte_last_r;
  logic byte_vld_r;
  logic [15:0] chan_r [NUM_CH];
  logic [15:0] tx_samp_r [NUM_CH];
  logic [15:0] rx_samp_r [NUM_CH];
  logic [15:0] rx_sh_r [NUM_CH];
  logic [15:0] gci_up_r [NUM_PAIR];
  logic [15:0] gci_dn_r [NUM_PAIR];
  logic cfg_fmt, cfg_half, cfg_edge;
  logic [2:0] cfg_ofs;
  assign cfg_fmt = ctrl_r[`CCHI_CTRL_FMT];
  assign cfg_half = ctrl_r[`CCHI_CTRL_HALF];
  assign cfg_edge = ctrl_r[`CCHI_CTRL_EDGE];
  assign cfg_ofs = ctrl_r[`CCHI_CTRL_OFS];

  // ****************************************
  // AHB-Lite slave: writes zero-wait, reads one wait state
  // ****************************************
  logic a_act_r, a_wr_r, bus_wr;
  logic [5:0] a_idx_r;
  logic [7:0] wa, wb;
  logic [2:0] wc;
  logic [31:0] rd_val;
  assign wa = {a_idx_r, 2'b00};
  assign wb = {wa[7:5], 5'h00};
  assign wc = wa[4:2];
  assign bus_wr = a_act_r && a_wr_r;

  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      a_act_r <= 1'b0;
      a_wr_r <= 1'b0;
      a_idx_r <= 6'h00;
      O_HREADYOUT <= 1'b1;
      O_HRDATA <= 32'h0000_0000;
      O_HRESP <= 1'b0;
    end else if (!O_HREADYOUT) begin
      O_HRDATA <= rd_val;
      O_HREADYOUT <= 1'b1;
      a_act_r <= 1'b0;
    end else if (I_HREADY) begin
      a_act_r <= I_HSEL && I_HTRANS[1];
      a_wr_r <= I_HWRITE;
      a_idx_r <= I_HADDR[7:2];
      if (I_HSEL && I_HTRANS[1] && !I_HWRITE) begin
        O_HREADYOUT <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    if (wa == `CCHI_OFS_CTRL) begin
      rd_val = {25'h0000000, ctrl_r};
    end else if (wa == `CCHI_OFS_STATUS) begin
      rd_val = {15'h0000, O_CTRL_SERIAL_OUT_EN, byte_last_r, 6'h00, byte_vld_r, gci_mode};
    end else if (wa == `CCHI_OFS_REPLY) begin
      rd_val = {24'h000000, reply_r};
    end else if (wb == `CCHI_OFS_CHAN) begin
      rd_val = {16'h0000, chan_r[wc]};
    end else if (wb == `CCHI_OFS_TXS) begin
      rd_val = {16'h0000, tx_samp_r[wc]};
    end else if (wb == `CCHI_OFS_RXS) begin
      rd_val = {16'h0000, rx_samp_r[wc]};
    end else if (wb == `CCHI_OFS_GCI && !wa[4]) begin
      rd_val = {gci_dn_r[wc[1:0]], gci_up_r[wc[1:0]]};
    end
  end

  logic ctl_done;
  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ctrl_r <= `CCHI_CTRL_RST;
      reply_r <= 8'h00;
      byte_vld_r <= 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
        chan_r[i] <= `CCHI_CHAN_RST;
        tx_samp_r[i] <= 16'h0000;
      end
      for (int i = 0; i < NUM_PAIR; i++) begin
        gci_up_r[i] <= `CCHI_GCI_UP_RST;
      end
    end else begin
      if (bus_wr && wa == `CCHI_OFS_CTRL) begin
        ctrl_r <= I_HWDATA[6:0];
      end
      if (bus_wr && wa == `CCHI_OFS_REPLY) begin
        reply_r <= I_HWDATA[7:0];
      end
      if (bus_wr && wb == `CCHI_OFS_CHAN) begin
        chan_r[wc] <= I_HWDATA[15:0];
      end
      if (bus_wr && wb == `CCHI_OFS_TXS) begin
        tx_samp_r[wc] <= I_HWDATA[15:0];
      end
      if (bus_wr && wb == `CCHI_OFS_GCI && !wa[4]) begin
        gci_up_r[wc[1:0]] <= I_HWDATA[15:0];
      end
      if (ctl_done) begin
        byte_vld_r <= 1'b1;
      end else if (bus_wr && wa == `CCHI_OFS_STATUS && I_HWDATA[`CCHI_STAT_BYTE_VLD]) begin
        byte_vld_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Serial control port
  // ****************************************
  cchi_ctl_state_type ctl_st_r;
  logic [2:0] ctl_cnt_r;
  logic [7:0] ctl_sh_r, rep_sh_r, ctl_byte;
  logic ctl_live;
  assign ctl_live = !gci_mode && !cs_s;
  assign ctl_byte = {ctl_sh_r[6:0], ci_s};
  assign ctl_done = ctl_live && serial_ctrl_clock_rise && ctl_st_r != CCHI_REPLY && ctl_cnt_r == 3'h7;

  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ctl_st_r <= CCHI_IDLE;
      ctl_cnt_r <= 3'h0;
      ctl_sh_r <= 8'h00;
      rep_sh_r <= 8'h00;
      byte_last_r <= 8'h00;
      O_CTRL_SERIAL_OUT <= 1'b0;
      O_CTRL_SERIAL_OUT_EN <= 1'b0;
    end else if (!ctl_live) begin
      ctl_st_r <= CCHI_IDLE;
      ctl_cnt_r <= 3'h0;
      O_CTRL_SERIAL_OUT_EN <= 1'b0;
    end else if (serial_ctrl_clock_rise) begin
      ctl_cnt_r <= ctl_cnt_r + 3'h1;
      case (ctl_st_r)
        CCHI_REPLY: begin
          if (ctl_cnt_r == 3'h7) begin
            ctl_st_r <= CCHI_IDLE;
            O_CTRL_SERIAL_OUT_EN <= 1'b0;
          end
        end
        default: begin
          ctl_sh_r <= ctl_byte;
          ctl_st_r <= CCHI_CMD;
          if (ctl_cnt_r == 3'h7) begin
            byte_last_r <= ctl_byte;
            if (ctl_byte[`CCHI_READ_CMD_BIT]) begin
              ctl_st_r <= CCHI_REPLY;
              rep_sh_r <= reply_r;
              O_CTRL_SERIAL_OUT_EN <= 1'b1;
            end
          end
        end
      endcase
    end else if (serial_ctrl_clock_fall && ctl_st_r == CCHI_REPLY) begin
      O_CTRL_SERIAL_OUT <= rep_sh_r[7];
      rep_sh_r <= {rep_sh_r[6:0], 1'b0};
    end
  end

  // ****************************************
  // TDM highway timing
  // ****************************************
  function automatic logic slot_hit(input logic [10:0] idx, input logic [6:0] sel,
                                    input logic lin);
    slot_hit = lin ? (idx[10:4] == sel) : (idx[9:3] == sel);
  endfunction

  function automatic logic [3:0] bit_of(input logic [10:0] idx, input logic lin);
    bit_of = lin ? idx[3:0] : {1'b0, idx[2:0]};
  endfunction

  logic tx_edge, rx_edge, fs_last_r, pcm_start, tx_ok, rx_ok, tx_upd, rx_take;
  logic [11:0] pe_cnt_r, pe_nxt, tx_rel, rx_rel, ofs12;
  logic [10:0] tx_idx, rx_idx;
  assign tx_edge = cfg_edge ? bclk_fall : bclk_rise;
  assign rx_edge = cfg_edge ? bclk_rise : bclk_fall;
  assign pcm_start = fs_s && !fs_last_r;
  assign pe_nxt = pcm_start ? 12'h000 : (&pe_cnt_r ? pe_cnt_r : pe_cnt_r + 12'h001);
  assign ofs12 = {9'h000, cfg_ofs};
  assign tx_rel = pe_nxt - ofs12;
  assign rx_rel = pe_cnt_r - ofs12;
  assign tx_idx = cfg_half ? tx_rel[11:1] : tx_rel[10:0];
  assign rx_idx = cfg_half ? rx_rel[11:1] : rx_rel[10:0];
  assign tx_ok = pe_nxt >= ofs12 && (cfg_half ? !tx_rel[11] : tx_rel[11:10] == 2'b00);
  assign rx_ok = pe_cnt_r >= ofs12 && (cfg_half ? !rx_rel[11] : rx_rel[11:10] == 2'b00);
  assign tx_upd = tx_edge && !(cfg_half && tx_rel[0]);
  assign rx_take = rx_edge && !gci_mode && !(cfg_half && rx_rel[0]);

  logic [NUM_CH-1:0] tx_hit, tx_bit, rx_hit, tx_hw, rx_hw;
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic [15:0] word;
    assign word = cfg_fmt ? {{2{tx_samp_r[c][13]}}, tx_samp_r[c][13:0]}
                          : {tx_samp_r[c][7:0], 8'h00};
    assign tx_hit[c] = tx_ok && slot_hit(tx_idx, chan_r[c][6:0], cfg_fmt);
    assign tx_bit[c] = word[~bit_of(tx_idx, cfg_fmt)];
    assign rx_hit[c] = rx_ok && slot_hit(rx_idx, chan_r[c][14:8], cfg_fmt);
    assign tx_hw[c] = chan_r[c][7];
    assign rx_hw[c] = chan_r[c][15];
  end

  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      pe_cnt_r <= 12'hFFF;
      fs_last_r <= 1'b0;
      O_TX_HIGHWAY_OUT_A <= 1'b0;
      O_TX_HIGHWAY_OUT_A_EN <= 1'b0;
      O_TX_HIGHWAY_OUT_B <= 1'b0;
      O_TX_HIGHWAY_OUT_B_EN <= 1'b0;
    end else if (gci_mode) begin
      O_TX_HIGHWAY_OUT_A_EN <= 1'b0;
      O_TX_HIGHWAY_OUT_B_EN <= 1'b0;
    end else if (tx_edge) begin
      pe_cnt_r <= pe_nxt;
      fs_last_r <= fs_s;
      if (tx_upd) begin
        O_TX_HIGHWAY_OUT_A_EN <= |(tx_hit & ~tx_hw);
        O_TX_HIGHWAY_OUT_A <= |(tx_hit & ~tx_hw & tx_bit);
        O_TX_HIGHWAY_OUT_B_EN <= |(tx_hit & tx_hw);
        O_TX_HIGHWAY_OUT_B <= |(tx_hit & tx_hw & tx_bit);
      end
    end
  end

  // ****************************************
  // GCI link timing
  // ****************************************
  logic fsc_last_r, gci_start, gu_ok, gd_ok, gu_own, gd_own;
  logic [9:0] ge_cnt_r, ge_nxt;
  logic [8:0] gu_idx, gd_idx;
  logic [7:0] gu_byte;
  assign gci_start = fsc_s && !fsc_last_r;
  assign ge_nxt = gci_start ? 10'h000 : (&ge_cnt_r ? ge_cnt_r : ge_cnt_r + 10'h001);
  assign gu_idx = dbl_s ? ge_nxt[9:1] : ge_nxt[8:0];
  assign gd_idx = dbl_s ? ge_cnt_r[9:1] : ge_cnt_r[8:0];
  assign gu_ok = !gu_idx[8] && (dbl_s || !ge_nxt[9]);
  assign gd_ok = !gd_idx[8] && (dbl_s || !ge_cnt_r[9]);
  assign gu_own = gu_ok && gu_idx[7] == tsel_s && !cs_s;
  assign gd_own = gd_ok && gd_idx[7] == tsel_s && !cs_s;

  always_comb begin
    case (gu_idx[4:3])
      2'h0: gu_byte = tx_samp_r[{gu_idx[6:5], 1'b0}][7:0];
      2'h1: gu_byte = tx_samp_r[{gu_idx[6:5], 1'b1}][7:0];
      2'h2: gu_byte = gci_up_r[gu_idx[6:5]][7:0];
      default: gu_byte = gci_up_r[gu_idx[6:5]][15:8];
    endcase
  end

  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ge_cnt_r <= 10'h3FF;
      fsc_last_r <= 1'b0;
      O_UPSTREAM_OUT <= 1'b0;
      O_UPSTREAM_OUT_EN <= 1'b0;
    end else if (!gci_mode) begin
      O_UPSTREAM_OUT_EN <= 1'b0;
    end else if (dcl_rise) begin
      ge_cnt_r <= ge_nxt;
      fsc_last_r <= fsc_s;
      if (!dbl_s || !ge_nxt[0]) begin
        O_UPSTREAM_OUT_EN <= gu_own && !gu_byte[~gu_idx[2:0]];
      end
    end
  end

  // ****************************************
  // Receive capture from highways and downstream
  // ****************************************
  logic [7:0] gd_sh_r, gd_byte;
  assign gd_byte = {gd_sh_r[6:0], dd_s};

  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      gd_sh_r <= 8'h00;
      for (int i = 0; i < NUM_CH; i++) begin
        rx_sh_r[i] <= 16'h0000;
        rx_samp_r[i] <= 16'h0000;
      end
      for (int i = 0; i < NUM_PAIR; i++) begin
        gci_dn_r[i] <= `CCHI_GCI_UP_RST;
      end
    end else if (rx_take) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (rx_hit[i]) begin
          rx_sh_r[i] <= {rx_sh_r[i][14:0], rx_hw[i] ? drb_s : dra_s};
          if (bit_of(rx_idx, cfg_fmt) == {cfg_fmt, 3'h7}) begin
            rx_samp_r[i] <= cfg_fmt ? {rx_sh_r[i][14:0], rx_hw[i] ? drb_s : dra_s}
                                    : {8'h00, rx_sh_r[i][6:0], rx_hw[i] ? drb_s : dra_s};
          end
        end
      end
    end else if (gci_mode && dcl_fall && (!dbl_s || !ge_cnt_r[0])) begin
      gd_sh_r <= gd_byte;
      if (gd_own && gd_idx[2:0] == 3'h7) begin
        case (gd_idx[4:3])
          2'h0: rx_samp_r[{gd_idx[6:5], 1'b0}] <= {8'h00, gd_byte};
          2'h1: rx_samp_r[{gd_idx[6:5], 1'b1}] <= {8'h00, gd_byte};
          2'h2: gci_dn_r[gd_idx[6:5]][7:0] <= gd_byte;
          default: gci_dn_r[gd_idx[6:5]][15:8] <= gd_byte;
        endcase
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_NRST);

  a_mode_quiets_pcm: assert property (gci_mode |=> !O_TX_HIGHWAY_OUT_A_EN
    && !O_TX_HIGHWAY_OUT_B_EN) else $error("highway driven in GCI mode");
  a_cs_abort: assert property (cs_s |=> ctl_st_r == CCHI_IDLE
    && !O_CTRL_SERIAL_OUT_EN) else $error("transfer kept after deselect");
  a_co_on_fall: assert property ($changed(O_CTRL_SERIAL_OUT) |-> $past(serial_ctrl_clock_fall))
    else $error("control output changed off a falling edge");
  a_reply_ignores_ci: assert property (ctl_st_r == CCHI_REPLY |=> $stable(ctl_sh_r)
    && $stable(byte_last_r)) else $error("command bits taken during reply");
  a_half_rate_hold: assert property (!gci_mode && tx_edge && cfg_half && tx_rel[0]
    |=> $stable(O_TX_HIGHWAY_OUT_A)) else $error("half rate bit changed early");
  a_tx_on_edge: assert property ($changed(O_TX_HIGHWAY_OUT_A) |-> $past(tx_edge))
    else $error("highway data changed off the chosen edge");
  a_lag_offset: assert property (!gci_mode && tx_edge && pcm_start && cfg_ofs != 3'h0
    |=> !O_TX_HIGHWAY_OUT_A_EN && !O_TX_HIGHWAY_OUT_B_EN) else $error("slot began before lag");
  a_hiz_unassigned: assert property (!gci_mode && tx_upd && !(|(tx_hit & ~tx_hw))
    |=> !O_TX_HIGHWAY_OUT_A_EN) else $error("highway A driven in a free slot");
  a_du_own_half: assert property ($rose(O_UPSTREAM_OUT_EN) |-> $past(dcl_rise)
    && $past(gu_idx[7]) == $past(tsel_s)) else $error("upstream driven in foreign half");

endmodule // cchi_top

// ==== cchi_host_model.sv ====
// Behavioural host processor driving the serial control port of the codec.
`timescale 1ns/10ps
module cchi_host_model (
  // Control port lines.
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_si,
  input wire logic i_so,
  input wire logic i_so_en
);
  logic so_last;
  logic so_seen;
  // A released output shows the inverse of its last value, never a stale copy.
  always @* begin
    if (i_so_en) begin
      so_last = i_so;
    end
  end
  assign so_seen = i_so_en ? i_so : ~so_last;
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
  end
  task automatic hold(input logic v);
    o_cs_n <= v;
  endtask
  task automatic open();
    #7;
    o_cs_n = 1'b0;
    #80;
  endtask
  // Bits go out MSB first; the reply is read just before each rise.
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < n; i++) begin
      o_si = tx[7 - i];
      #80;
      rx[7 - i] = so_seen;
      o_sclk = 1'b1;
      #80;
      o_sclk = 1'b0;
    end
  endtask
  // The clock keeps running one full cycle after deselect.
  task automatic close();
    o_cs_n = 1'b1;
    #80;
    o_sclk = 1'b1;
    #80;
    o_sclk = 1'b0;
    #80;
  endtask
endmodule // cchi_host_model

// ==== tb_top.sv ====
// Self-checking bench for the codec host interfaces.
`timescale 1ns/10ps
module tb_top;
  import cchi_pkg::*;
  localparam logic [39:0] ONES = 40'hFFFFFFFFFF;
  logic clk, nrst, hwrite, sel_n, bclk, fs, rx_a, rx_b, dd, hreadyout, hresp;
  logic sclk, cs_n, si, so, so_en, ta, tae, tb_b, tbe, up, up_en, tsel, dbl;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [39:0] ca, cae, cb, cbe, cu;
  logic [7:0] r;
  int errors, check_count;
  cchi_top cchi_top_inst (.I_MCLK(clk), .I_NRST(nrst), .I_HSEL(1'b1), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
    .I_HREADY(hreadyout), .O_HRDATA(hrdata), .O_HREADYOUT(hreadyout), .O_HRESP(hresp),
    .I_INTERFACE_SELECT_N(sel_n), .I_SLOT_HALF_SEL(tsel), .I_DOUBLE_RATE(dbl),
    .I_SERIAL_CTRL_CLOCK(sclk), .I_CS_N(cs_n), .I_CTRL_SERIAL_IN(si),
    .O_CTRL_SERIAL_OUT(so), .O_CTRL_SERIAL_OUT_EN(so_en), .I_BIT_CLOCK(bclk),
    .I_HIGHWAY_FRAME_SYNC(fs), .I_RX_HIGHWAY_IN_A(rx_a), .I_RX_HIGHWAY_IN_B(rx_b),
    .O_TX_HIGHWAY_OUT_A(ta), .O_TX_HIGHWAY_OUT_A_EN(tae), .O_TX_HIGHWAY_OUT_B(tb_b),
    .O_TX_HIGHWAY_OUT_B_EN(tbe), .I_DATA_CLOCK(bclk), .I_GCI_FRAME_SYNC(fs),
    .I_DOWNSTREAM_IN(dd), .O_UPSTREAM_OUT(up), .O_UPSTREAM_OUT_EN(up_en));
  cchi_host_model host (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(si), .i_so(so), .i_so_en(so_en));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // The link clock runs free at 160 ns, offset from the system clock.
  initial begin
    bclk = 1'b0;
    #7;
    forever #80 bclk = ~bclk;
  end
  function automatic logic [39:0] put(input logic [15:0] v, input int s, input int w);
    logic [39:0] x;
    x = 40'h0;
    for (int j = 0; j < w; j++) x[s + j] = v[w - 1 - j];
    return x;
  endfunction
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [39:0] e, input logic [39:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
    chk("hresp", 40'h0, {39'h0, hresp});
  endtask
  task automatic rdc(input string n, input logic [31:0] a, input logic [31:0] e,
                     input logic [31:0] m);
    ahb(1'b0, a, 32'h0);
    chk(n, {8'h0, e}, {8'h0, q & m});
  endtask
  // One frame: sync before bit 0, receive lines per bit, transmit captured late in each bit.
  task automatic frame(input logic [39:0] da, input logic [39:0] db, input logic [39:0] dv);
    @(negedge bclk);
    @(posedge clk);
    fs <= 1'b1;
    for (int k = 0; k < 40; k++) begin
      @(posedge bclk);
      @(posedge clk);
      rx_a <= da[k];
      rx_b <= db[k];
      dd <= dv[k];
      fs <= (k == 0);
      #125;
      ca[k] = ta;
      cae[k] = tae;
      cb[k] = tb_b;
      cbe[k] = tbe;
      cu[k] = up_en ? up : 1'b1;
    end
  endtask
  initial begin
    #300000;
    errors++;
    end_sim();
  end
  initial begin
    {nrst, hwrite, sel_n, fs, rx_a, rx_b, dd, tsel, dbl} = 9'h004;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    {errors, check_count} = 0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    // ********************
    // Register map.
    // ********************
    rdc("ctrl_reset", 32'h00, 32'h0, 32'hFF);
    rdc("gci_up_reset", 32'h80, 32'hFFFF, 32'hFFFF);
    rdc("unmapped", 32'hFC, 32'h0, 32'hFFFFFFFF);
    ahb(1'b1, 32'h2C, 32'h8201);
    rdc("chan3", 32'h2C, 32'h8201, 32'hFFFF);
    // ********************
    // Control port.
    // ********************
    host.open();
    host.xfer(8'h35, 8, r);
    host.close();
    rdc("status_byte", 32'h04, 32'h3502, 32'h1FF03);
    ahb(1'b1, 32'h04, 32'h2);
    host.open();
    host.xfer(8'hF0, 4, r);
    host.close();
    host.open();
    host.xfer(8'h12, 8, r);
    host.close();
    rdc("status_abort", 32'h04, 32'h1202, 32'hFF02);
    ahb(1'b1, 32'h08, 32'hA5);
    host.open();
    host.xfer(8'h81, 8, r);
    host.xfer(8'hFF, 8, r);
    host.close();
    chk("reply", 40'hA5, {32'h0, r});
    rdc("status_read", 32'h04, 32'h8100, 32'hFF00);
    // ********************
    // Highways.
    // ********************
    ahb(1'b1, 32'h40, 32'hC3);
    ahb(1'b1, 32'h20, 32'h8201);
    frame(ONES, ~put(16'hFF, 16, 8) | put(16'h5A, 16, 8), ONES);
    chk("a_en", put(16'hFFFF, 0, 16), cae);
    chk("a_data", put(16'hC3, 8, 8), ca & cae);
    chk("b_en", 40'h0, cbe);
    rdc("rx_comp", 32'h60, 32'h5A, 32'hFFFF);
    ahb(1'b1, 32'h40, 32'h2ABC);
    ahb(1'b1, 32'h20, 32'h0181);
    ahb(1'b1, 32'h00, 32'h31);
    frame(~put(16'hFFFF, 19, 16) | put(16'hE5A6, 19, 16), ONES, ONES);
    chk("b_en_lin", put(16'hFFFF, 19, 16), cbe);
    chk("b_data_lin", put(16'hEABC, 19, 16), cb & cbe);
    chk("a_en_lin", put(16'hFFFF, 3, 16) | put(16'hFFFF, 19, 16), cae);
    rdc("rx_lin", 32'h60, 32'hE5A6, 32'hFFFF);
    ahb(1'b1, 32'h00, 32'h06);
    frame(~put(16'hFFFF, 16, 16) | put(16'h5AA5, 16, 16), ONES, ONES);
    chk("b_en_half", put(16'hFFFF, 16, 16), cbe);
    chk("b_data_half", put(16'hCFF0, 16, 16), cb & cbe);
    rdc("rx_half", 32'h60, 32'h3C, 32'hFFFF);
    // ********************
    // GCI link.
    // ********************
    ahb(1'b1, 32'h00, 32'h0);
    ahb(1'b1, 32'h40, 32'h96);
    ahb(1'b1, 32'h80, 32'hFF3C);
    @(posedge clk);
    sel_n <= 1'b1;
    host.hold(1'b0);
    repeat (8) @(posedge clk);
    rdc("gci_mode", 32'h04, 32'h1, 32'h1);
    frame(ONES, ONES, ~put(16'hFF, 0, 8) | put(16'h71, 0, 8));
    chk("upstream", put(16'h96, 0, 8) | put(16'h3C, 16, 8) | put(16'hFF, 24, 8), cu);
    rdc("gci_rx", 32'h60, 32'h71, 32'hFFFF);
    rdc("gci_pair0", 32'h80, 32'hFFFFFF3C, 32'hFFFFFFFF);
    tsel <= 1'b1;
    frame(ONES, ONES, ONES);
    chk("up_other_half", ONES, cu);
    tsel <= 1'b0;
    dbl <= 1'b1;
    frame(ONES, ONES, ONES);
    chk("up_double", put(16'hC33C, 0, 16) | put(16'h0F, 32, 8), cu);
    end_sim();
  end
endmodule // tb_top
